// ===== bench/mhp_link_chk.sv
// Watches the wires between the two ends; sees only interface signals
module mhp_link_chk (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic hostBusOe,
    input wire logic devBusOe,
    input wire logic devMemOe,
    input wire logic ramOe,
    input wire logic host_addr_strobe_n,
    input wire logic readWrite,
    input wire logic mem_addr_strobe,
    input wire logic memOutEnable_n,
    input wire logic memWriteEnable_n
);
    timeunit 1ns;
    timeprecision 1ns;

    // One clock domain, so one default clocking and reset gate
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);

    // Memory strobe free runs at two clocks high, two clocks low
    a_strobe_high_two:
        assert property ($rose(mem_addr_strobe) |-> mem_addr_strobe ##1 mem_addr_strobe ##1 !mem_addr_strobe)
        else $error("memory strobe high phase not two cycles");
    a_strobe_low_two:
        assert property ($fell(mem_addr_strobe) |-> !mem_addr_strobe ##1 !mem_addr_strobe ##1 mem_addr_strobe)
        else $error("memory strobe low phase not two cycles");
    // Address phase: device owns the bus, memory stays quiet
    a_addr_phase_drive:
        assert property (mem_addr_strobe |-> devMemOe && memOutEnable_n && memWriteEnable_n)
        else $error("low address not driven during strobe high");
    // Memory drives only under output enable, and the device lets go then
    a_ram_under_oe:
        assert property (ramOe |-> !memOutEnable_n && !devMemOe)
        else $error("memory drives without output enable");
    a_oe_we_apart:
        assert property (!(!memOutEnable_n && !memWriteEnable_n))
        else $error("read and write enables low together");
    a_write_data_drive:
        assert property (!memWriteEnable_n |-> devMemOe && !mem_addr_strobe)
        else $error("write enable low without data driven");
    // Host bus is shared; two drivers at once would clash
    a_host_no_clash:
        assert property (!(devBusOe && hostBusOe))
        else $error("host bus driven by both ends");
    a_read_drive_rw:
        assert property ($rose(devBusOe) |-> readWrite)
        else $error("device drives host bus without a read");
    a_addr_byte_host:
        assert property ($fell(host_addr_strobe_n) |-> hostBusOe && !devBusOe)
        else $error("no address byte at address strobe fall");
    // Once the host raises the address strobe the next access begins; drivers must be off
    a_drive_in_access:
        assert property (devBusOe |-> !host_addr_strobe_n)
        else $error("device drives host bus outside an access");
endmodule

// ===== bench/tb.sv
module tb;
    timeunit 1ns;
    timeprecision 1ns;

    logic        sys_clk = 1'b0;
    logic        rst_n   = 1'b0;
    logic        start, doRead, useHighProto, deselect, done, busy, wrStrobe;
    logic [7:0]  addr, wdata, rdata, regAddr, wrData, rdData, memWrData, memRdData;
    logic [7:0]  expAddr, expWr;   // Model: last selected address, last write byte
    logic        memReq, memWrite, memDone;
    logic [13:0] memAddr;
    logic [7:0]  mm [int];         // Model of the private memory
    logic [13:0] adq [$];
    int          miscompares = 0;
    int          n_checks    = 0;
    int          wrCount     = 0;
    int          seed        = 32'h969CE984;
    int          i;

    // 10 MHz clock
    always #50 sys_clk = ~sys_clk;

    // Count write pulses; a missing or doubled pulse shows here
    always @(posedge sys_clk) if (wrStrobe === 1'b1) wrCount++;

    mhp_link_if link ();
    mhp_device mhp_device_inst (.sys_clk(sys_clk), .rst_n(rst_n), .link(link.device), .regAddr(regAddr),
        .wrData(wrData), .wrStrobe(wrStrobe), .rdData(rdData), .memReq(memReq), .memWrite(memWrite),
        .memAddr(memAddr), .memWrData(memWrData), .memRdData(memRdData), .memDone(memDone));
    mhp_host mhp_host_inst (.sys_clk(sys_clk), .rst_n(rst_n), .link(link.host), .start(start), .doRead(doRead),
        .useHighProto(useHighProto), .deselect(deselect), .addr(addr), .wdata(wdata), .rdata(rdata), .done(done),
        .busy(busy));
    mhp_link_chk mhp_link_chk_inst (.sys_clk(sys_clk), .rst_n(rst_n), .hostBusOe(link.hostBusOe),
        .devBusOe(link.devBusOe), .devMemOe(link.devMemOe), .ramOe(link.ramOe),
        .host_addr_strobe_n(link.host_addr_strobe_n), .readWrite(link.readWrite),
        .mem_addr_strobe(link.mem_addr_strobe), .memOutEnable_n(link.memOutEnable_n),
        .memWriteEnable_n(link.memWriteEnable_n));

    task automatic give_verdict;
        $display("checks=%0d miscompares=%0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // A wait that runs out of its bound ends the run
    task automatic timed_out;
        miscompares++;
        $display("[FAIL] t=%0t wait limit got=%h exp=%h", $time, 8'h00, 8'h01);
        give_verdict();
    endtask

    // One host access through the far end, then compare with the model
    task automatic host_access(input logic rd, input logic hp, input logic desel,
                               input logic [7:0] a, input logic [7:0] w, input logic [7:0] r);
        int         k;
        logic [7:0] got;
        k = 0;
        while (busy !== 1'b0) begin
            @(posedge sys_clk);
            k++;
            if (k > 200) timed_out();
        end
        doRead    <= rd;
        useHighProto <= hp;
        deselect  <= desel;
        addr      <= a;
        wdata     <= w;
        rdData    <= r;
        start     <= 1'b1;
        @(posedge sys_clk);
        start   <= 1'b0;
        wrCount = 0;
        k = 0;
        do begin
            @(posedge sys_clk);
            k++;
            if (k > 400) timed_out();
        end while (done !== 1'b1);
        got = rdata;
        // Write detection passes a synchroniser, so give it time to land
        repeat (8) @(posedge sys_clk);
        if (rd) check(got, desel ? 8'hFF : r);
        check(8'(wrCount), (!rd && !desel) ? 8'h01 : 8'h00);
        // A deselected access must leave both the address and the write byte alone
        if (!desel) expAddr = a;
        if (!rd && !desel) expWr = w;
        check(regAddr, expAddr);
        check(wrData, expWr);
    endtask

    // One private memory cycle; reads compare with the model
    task automatic mem_access(input logic wr, input logic [13:0] a, input logic [7:0] d);
        int k;
        memReq    <= 1'b1;
        memWrite  <= wr;
        memAddr   <= a;
        memWrData <= d;
        k = 0;
        do begin
            @(posedge sys_clk);
            k++;
            if (k > 100) timed_out();
        end while (memDone !== 1'b1);
        memReq <= 1'b0;
        if (wr) mm[int'(a)] = d;
        else check(memRdData, mm[int'(a)]);
        @(posedge sys_clk);
    endtask

    initial begin
        start = 1'b0; doRead = 1'b0; useHighProto = 1'b0; deselect = 1'b0;
        expAddr = 8'h00; expWr = 8'h00;
        addr = 8'h00; wdata = 8'h00; rdData = 8'h00;
        memReq = 1'b0; memWrite = 1'b0; memAddr = 14'h0000; memWrData = 8'h00;
        repeat (20) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(posedge sys_clk);
        // Every mix of direction, protocol and select, random bytes
        for (i = 0; i < 32; i++) begin
            host_access(i[0], i[1], i[3:2] == 2'h3, 8'($random(seed)), 8'($random(seed)), 8'($random(seed)));
        end
        // Both ends of the 16K space, then random places, then read back
        adq = '{14'h0000, 14'h3FFF};
        for (i = 0; i < 6; i++) adq.push_back(14'($random(seed)));
        foreach (adq[j]) mem_access(1'b1, adq[j], 8'($random(seed)));
        foreach (adq[j]) mem_access(1'b0, adq[j], 8'h00);
        // Overwrite then read at once
        mem_access(1'b1, 14'h3FFF, 8'($random(seed)));
        mem_access(1'b0, 14'h3FFF, 8'h00);
        give_verdict();
    end
endmodule

// ===== core/mhp_device.sv
// How it works
// - One 8-bit bus, address then data
// - Address strobe fall latches address, strobe, select; address only when select low
// - Only respond when latched select low
// - Strobe-high protocol: drive read while strobe low
// - Strobe-high protocol: write latched by read/write low
// - Strobe-low protocol: read/write sets direction, strobe high
// - Read/write low writes, high reads
// - Low address while strobe high, data while low
// - Six pins carry high address bits
// - Output enable low lets memory drive
// - Write enable low writes, high reads
// - Memory space is 16K bytes
// - Memory address strobe toggles continuously
module mhp_device (
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    mhp_link_if.device       link,
    output logic [7:0]       regAddr,      // Latched host register address
    output logic [7:0]       wrData,       // Host write data
    output logic             wrStrobe,     // One-cycle pulse per host write
    input  wire logic [7:0]  rdData,       // Register read value from core
    input  wire logic        memReq,       // Memory request, held until memDone
    input  wire logic        memWrite,
    input  wire logic [13:0] memAddr,
    input  wire logic [7:0]  memWrData,
    output logic [7:0]       memRdData,
    output logic             memDone       // One-cycle pulse at end of memory cycle
);
    // Three-stage synchronisers for the host pins
    logic [2:0] asSync, dataSync, rwSync, csSync;
    logic [7:0] busS1, busS2, busS3;
    logic       asStable, dataStable, rwStable;
    logic       next_asStable, next_dataStable, next_rwStable;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            asSync <= 3'h7;
            dataSync <= 3'h0;
            rwSync <= 3'h7;
            csSync <= 3'h7;
            busS1  <= 8'h00;
            busS2  <= 8'h00;
            busS3  <= 8'h00;
        end else begin
            asSync <= {asSync[1:0], link.host_addr_strobe_n};
            dataSync <= {dataSync[1:0], link.host_data_strobe};
            rwSync <= {rwSync[1:0], link.readWrite};
            csSync <= {csSync[1:0], link.chipSelect_n};
            busS1  <= link.hostBusIn;
            busS2  <= busS1;
            busS3  <= busS2;
        end
    end

    // A change counts once stages two and three agree
    always_comb begin
        next_asStable = (asSync[1] == asSync[2]) ? asSync[2] : asStable;
        next_dataStable = (dataSync[1] == dataSync[2]) ? dataSync[2] : dataStable;
        next_rwStable = (rwSync[1] == rwSync[2]) ? rwSync[2] : rwStable;
    end

    // Host access state
    mhp_pkg::mhp_proto_t proto, next_proto;
    logic       selected, next_selected;
    logic [7:0] next_regAddr, next_wrData;
    logic       next_wrStrobe;
    logic [7:0] next_devBusOut;
    logic       next_devBusOe;
    logic       asFall, dataFall, rwFall;

    always_comb begin
        asFall         = asStable && !next_asStable;
        dataFall       = dataStable && !next_dataStable;
        rwFall         = rwStable && !next_rwStable;
        next_proto     = proto;
        next_selected  = selected;
        next_regAddr   = regAddr;
        next_wrData    = wrData;
        next_wrStrobe  = 1'b0;
        next_devBusOut = rdData;
        next_devBusOe  = 1'b0;
        if (asFall) begin
            // Stage-three copies of strobe, select and bus match the strobe edge
            if (!csSync[2]) begin
                next_regAddr = busS3;
            end
            next_proto    = dataSync[2] ? mhp_pkg::MHP_PROTO_DSHIGH
                                        : mhp_pkg::MHP_PROTO_DSLOW;
            next_selected = !csSync[2];
        end else if (selected && !next_asStable) begin
            // A high address strobe opens the next access and the host owns the bus,
            // so the protocol left from the last access must not switch drivers on
            if (proto == mhp_pkg::MHP_PROTO_DSHIGH) begin
                // Read drivers on while strobe low and read/write high
                next_devBusOe = !next_dataStable && next_rwStable;
                if (rwFall) begin
                    next_wrData   = busS3;
                    next_wrStrobe = 1'b1;
                end
            end else begin
                next_devBusOe = next_dataStable && next_rwStable;
                if (dataFall && !rwStable) begin
                    // Data sampled at the end of the high strobe, when it is surely settled
                    next_wrData   = busS3;
                    next_wrStrobe = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            asStable       <= 1'b1;
            dataStable     <= 1'b0;
            rwStable       <= 1'b1;
            proto          <= mhp_pkg::MHP_PROTO_DSLOW;
            selected       <= 1'b0;
            regAddr        <= 8'h00;
            wrData         <= 8'h00;
            wrStrobe       <= 1'b0;
            link.devBusOut <= 8'h00;
            link.devBusOe  <= 1'b0;
        end else begin
            asStable       <= next_asStable;
            dataStable     <= next_dataStable;
            rwStable       <= next_rwStable;
            proto          <= next_proto;
            selected       <= next_selected;
            regAddr        <= next_regAddr;
            wrData         <= next_wrData;
            wrStrobe       <= next_wrStrobe;
            link.devBusOut <= next_devBusOut;
            link.devBusOe  <= next_devBusOe;
        end
    end

    // Memory cycle: address phase with strobe high, data phase with strobe low.
    // The strobe runs free so external latches never see a stall.
    mhp_pkg::mhp_mphase_t phase, next_phase;
    logic [1:0]  halfCnt, next_halfCnt;
    logic        busy, next_busy;
    logic        cycWrite, next_cycWrite;
    logic [7:0]  next_devMemOut, next_memRdData;
    logic        next_devMemOe, next_strobe, next_oe_n, next_we_n, next_memDone;
    logic [5:0]  next_high;

    always_comb begin
        next_phase     = phase;
        next_halfCnt   = halfCnt + 2'h1;
        next_busy      = busy;
        next_cycWrite  = cycWrite;
        next_devMemOut = link.devMemOut;
        next_devMemOe  = link.devMemOe;
        next_strobe    = link.mem_addr_strobe;
        next_oe_n      = link.memOutEnable_n;
        next_we_n      = link.memWriteEnable_n;
        next_high      = link.mem_high_addr;
        next_memRdData = memRdData;
        next_memDone   = 1'b0;
        if (halfCnt == mhp_pkg::STROBE_HALF - 2'h1) begin
            next_halfCnt = 2'h0;
            case (phase)
                mhp_pkg::MHP_MEM_DATA: begin
                    // End of data phase: finish any access, start next address phase
                    if (busy && !cycWrite) begin
                        next_memRdData = link.memBusIn;
                    end
                    next_memDone   = busy;
                    next_busy      = memReq && !busy;
                    next_cycWrite  = memWrite;
                    next_phase     = mhp_pkg::MHP_MEM_ADDR;
                    next_strobe    = 1'b1;
                    next_oe_n      = 1'b1;
                    next_we_n      = 1'b1;
                    next_devMemOut = memAddr[7:0];
                    next_devMemOe  = 1'b1;
                    next_high      = memAddr[13:8];
                end
                default: begin
                    next_phase    = mhp_pkg::MHP_MEM_DATA;
                    next_strobe   = 1'b0;
                    next_devMemOut = memWrData;
                    next_devMemOe = busy && cycWrite;
                    next_oe_n     = !(busy && !cycWrite);
                    next_we_n     = !(busy && cycWrite);
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            phase                 <= mhp_pkg::MHP_MEM_DATA;
            halfCnt               <= 2'h0;
            busy                  <= 1'b0;
            cycWrite              <= 1'b0;
            memRdData             <= 8'h00;
            memDone               <= 1'b0;
            link.devMemOut        <= 8'h00;
            link.devMemOe         <= 1'b0;
            link.mem_addr_strobe  <= 1'b0;
            link.memOutEnable_n   <= 1'b1;
            link.memWriteEnable_n <= 1'b1;
            link.mem_high_addr    <= 6'h00;
        end else begin
            phase                 <= next_phase;
            halfCnt               <= next_halfCnt;
            busy                  <= next_busy;
            cycWrite              <= next_cycWrite;
            memRdData             <= next_memRdData;
            memDone               <= next_memDone;
            link.devMemOut        <= next_devMemOut;
            link.devMemOe         <= next_devMemOe;
            link.mem_addr_strobe  <= next_strobe;
            link.memOutEnable_n   <= next_oe_n;
            link.memWriteEnable_n <= next_we_n;
            link.mem_high_addr    <= next_high;
        end
    end
endmodule

// ===== core/mhp_host.sv
// Far end: a host that runs register accesses and the private memory
module mhp_host (
    input  wire logic       sys_clk,
    input  wire logic       rst_n,
    mhp_link_if.host        link,
    input  wire logic       start,       // Pulse: begin one access
    input  wire logic       doRead,
    input  wire logic       useHighProto, // Protocol: data strobe high at address time
    input  wire logic       deselect,    // Chip select high for this access
    input  wire logic [7:0] addr,
    input  wire logic [7:0] wdata,
    output logic [7:0]      rdata,
    output logic            done,        // One-cycle pulse at end of access
    output logic            busy
);
    typedef enum {MHP_H_IDLE, MHP_H_ADDR, MHP_H_LATCH, MHP_H_DATA, MHP_H_STROBE, MHP_H_END} mhp_hstate_t;
    mhp_hstate_t st, next_st;
    logic [2:0]  cnt, next_cnt;
    logic        rd, next_rd, hiProto, next_hiProto, csn, next_csn;
    logic [7:0]  ad, next_ad, wd, next_wd, next_rdata, next_out;
    logic        next_oe, next_as, next_strb, next_rw, next_done, next_busy, tick;
    logic [13:0] ramAddr;
    logic [7:0]  ram [0:mhp_pkg::MEM_DEPTH-1];
    logic [7:0]  lowLatch, next_lowLatch;

    // Access sequencer; every phase is held long enough for the device synchronisers
    always_comb begin
        tick         = (cnt == mhp_pkg::HOST_HOLD);
        next_cnt     = tick ? 3'h0 : cnt + 3'h1;
        next_st      = st;
        next_rd      = rd;
        next_hiProto = hiProto;
        next_csn     = csn;
        next_ad      = ad;
        next_wd      = wd;
        next_rdata   = rdata;
        next_out     = link.hostBusOut;
        next_oe      = link.hostBusOe;
        next_as      = link.host_addr_strobe_n;
        next_strb    = link.host_data_strobe;
        next_rw      = link.readWrite;
        next_done    = 1'b0;
        next_busy    = busy;
        case (st)
            MHP_H_IDLE: begin
                next_cnt = 3'h0;
                if (start) begin
                    next_st      = MHP_H_ADDR;
                    next_rd      = doRead;
                    next_hiProto = useHighProto;
                    next_csn     = deselect;
                    next_ad      = addr;
                    next_wd      = wdata;
                    next_busy    = 1'b1;
                end
            end
            MHP_H_ADDR: begin
                // Address byte and strobe levels set up before the latch edge
                next_out  = ad;
                next_oe   = 1'b1;
                next_strb = hiProto;
                next_rw   = 1'b1;
                next_as   = 1'b1;
                if (tick) begin
                    next_st = MHP_H_LATCH;
                end
            end
            MHP_H_LATCH: begin
                next_as = 1'b0;
                if (tick) begin
                    next_st   = MHP_H_DATA;
                    next_oe   = !rd;
                    next_out  = wd;
                    next_rw   = hiProto || rd;
                    next_strb = hiProto;
                end
            end
            MHP_H_DATA: begin
                if (tick) begin
                    next_st = MHP_H_STROBE;
                    if (!hiProto) begin
                        next_strb = 1'b1;
                    end else if (rd) begin
                        next_strb = 1'b0;
                    end else begin
                        next_rw = 1'b0;
                    end
                end
            end
            MHP_H_STROBE: begin
                if (tick) begin
                    next_st   = MHP_H_END;
                    next_strb = hiProto;
                    next_rw   = 1'b1;
                    if (rd) begin
                        next_rdata = link.hostBusIn;
                    end
                end
            end
            default: begin
                if (tick) begin
                    next_st   = MHP_H_IDLE;
                    next_oe   = 1'b0;
                    next_as   = 1'b1;
                    next_done = 1'b1;
                    next_busy = 1'b0;
                end
            end
        endcase
        // Memory model: low address byte is followed while the strobe is high, held once it falls
        next_lowLatch = link.mem_addr_strobe ? link.memBusIn : lowLatch;
    end

    assign ramAddr = {link.mem_high_addr, lowLatch};

    // Memory answers like an asynchronous part, so it lets go the moment output enable rises
    always_comb begin
        link.ramOut = ram[ramAddr];
        link.ramOe  = !link.memOutEnable_n && !link.mem_addr_strobe;
    end

    always_ff @(posedge sys_clk) begin
        if (!link.memWriteEnable_n && !link.mem_addr_strobe) ram[ramAddr] <= link.memBusIn;
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            st                      <= MHP_H_IDLE;
            cnt                     <= 3'h0;
            rd                      <= 1'b0;
            hiProto                 <= 1'b0;
            csn                     <= 1'b1;
            ad                      <= 8'h00;
            wd                      <= 8'h00;
            rdata                   <= 8'h00;
            done                    <= 1'b0;
            busy                    <= 1'b0;
            lowLatch                <= 8'h00;
            link.hostBusOut         <= 8'h00;
            link.hostBusOe          <= 1'b0;
            link.host_addr_strobe_n <= 1'b1;
            link.host_data_strobe   <= 1'b0;
            link.readWrite          <= 1'b1;
            link.chipSelect_n       <= 1'b1;
        end else begin
            st                      <= next_st;
            cnt                     <= next_cnt;
            rd                      <= next_rd;
            hiProto                 <= next_hiProto;
            csn                     <= next_csn;
            ad                      <= next_ad;
            wd                      <= next_wd;
            rdata                   <= next_rdata;
            done                    <= next_done;
            busy                    <= next_busy;
            lowLatch                <= next_lowLatch;
            link.hostBusOut         <= next_out;
            link.hostBusOe          <= next_oe;
            link.host_addr_strobe_n <= next_as;
            link.host_data_strobe   <= next_strb;
            link.readWrite          <= next_rw;
            link.chipSelect_n       <= next_csn;
        end
    end
endmodule

// ===== core/mhp_link_if.sv
interface mhp_link_if;
    // Host side: multiplexed bus as three signals per party
    logic [7:0] hostBusIn;      // Resolved bus level seen by both
    logic [7:0] hostBusOut;
    logic       hostBusOe;
    logic [7:0] devBusOut;
    logic       devBusOe;
    logic       host_addr_strobe_n;
    logic       host_data_strobe;
    logic       readWrite;
    logic       chipSelect_n;
    // Memory side
    logic [7:0] memBusIn;       // Resolved memory bus level
    logic [7:0] devMemOut;
    logic       devMemOe;
    logic [7:0] ramOut;
    logic       ramOe;
    logic [5:0] mem_high_addr;
    logic       mem_addr_strobe;
    logic       memOutEnable_n;
    logic       memWriteEnable_n;
    // Bus resolution: whoever enables drives, the device wins a clash
    assign hostBusIn = devBusOe ? devBusOut : (hostBusOe ? hostBusOut : 8'hFF);
    assign memBusIn  = devMemOe ? devMemOut : (ramOe ? ramOut : 8'hFF);
    modport device (input hostBusIn, host_addr_strobe_n, host_data_strobe, readWrite, chipSelect_n, memBusIn,
                    output devBusOut, devBusOe, devMemOut, devMemOe, mem_high_addr, mem_addr_strobe,
                    memOutEnable_n, memWriteEnable_n);
    modport host (input hostBusIn, devBusOut, devBusOe, mem_high_addr, mem_addr_strobe, memOutEnable_n,
                  memWriteEnable_n, memBusIn,
                  output hostBusOut, hostBusOe, host_addr_strobe_n, host_data_strobe, readWrite, chipSelect_n,
                  ramOut, ramOe);
endinterface

// ===== core/mhp_pkg.sv
package mhp_pkg;
    // Host bus and memory bus widths
    localparam int DATA_W     = 8;
    localparam int HIGH_W     = 6;
    localparam int MEM_ADDR_W = 14;                 // 16K locations
    localparam int MEM_DEPTH  = 16384;
    // Memory strobe half period in sys_clk cycles
    localparam logic [1:0] STROBE_HALF = 2'h2;
    // Far-end host: last count of each access phase, long enough for the device synchronisers
    localparam logic [2:0] HOST_HOLD   = 3'h6;
    // Host access protocols, chosen by the data strobe level at address strobe time
    typedef enum logic {MHP_PROTO_DSLOW, MHP_PROTO_DSHIGH} mhp_proto_t;
    // Memory cycle phases
    typedef enum logic [1:0] {MHP_MEM_ADDR, MHP_MEM_DATA} mhp_mphase_t;
endpackage
